// ==== core/mls_pkg.sv ====
// Purpose: shared constants and types for the mac loopback and start indication block
// Assumes: one 10 MHz clock, byte-wide streams on both sides
// Notes:   register indices are word indices; byte address is four times the index
package mls_pkg;

  // ==========================================================================
  // bus geometry
  localparam int          ADDR_W        = 18;
  localparam int          DATA_W        = 32;
  localparam int          REG_W         = 16;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ==========================================================================
  // register indices, reset values and writable masks
  localparam logic [15:0] LOOPBACK_IDX  = 16'h8055;
  localparam logic [15:0] SOP_CTRL_IDX  = 16'h805A;
  localparam logic [15:0] LOOPBACK_RST  = 16'h000A;
  localparam logic [15:0] SOP_CTRL_RST  = 16'h001B;
  localparam logic [15:0] LOOPBACK_MASK = 16'h000F;
  localparam logic [15:0] SOP_CTRL_MASK = 16'h003F;

  // ==========================================================================
  // field positions of the loopback configuration register
  localparam int LB_LOCAL_EN_BIT   = 0;
  localparam int LB_TX_SUPP_BIT    = 1;
  localparam int LB_REMOTE_EN_BIT  = 2;
  localparam int LB_RX_SUPP_BIT    = 3;

  // field positions of the start indication control register
  localparam int SOP_RX_EN_BIT     = 0;
  localparam int SOP_RX_SFD_BIT    = 1;
  localparam int SOP_RX_LEN_BIT    = 2;
  localparam int SOP_TX_EN_BIT     = 3;
  localparam int SOP_TX_SFD_BIT    = 4;
  localparam int SOP_TX_LEN_BIT    = 5;

  // ==========================================================================
  // frame constants
  localparam logic [7:0]  SFD_BYTE       = 8'hD5;
  localparam logic [3:0]  PREAMBLE_LIMIT = 4'h8;

  // start indication tracker states, one-hot
  typedef enum logic [3:0] {
    MLS_IDLE   = 4'b0001,
    MLS_PRE    = 4'b0010,
    MLS_ACTIVE = 4'b0100,
    MLS_SKIP   = 4'b1000
  } mls_sop_state_type;

endpackage

// ==== core/mls_sop_detect.sv ====
// Purpose: start-of-packet indication tracker for one direction
// Assumes: dv_i and data_i come from logic on the same clock
// Notes:   indication is registered, so it lines up with a one-cycle delayed stream
`timescale 1ns/10ps
module mls_sop_detect
  import mls_pkg::*;
(
  input  wire logic       clock_i,    // block clock
  input  wire logic       rst_n_i,    // synchronised reset, active low
  input  wire logic       en_i,       // indication generation enable
  input  wire logic       sfd_mode_i, // assert on delimiter instead of valid
  input  wire logic       len_chk_i,  // assert after eight bytes without delimiter
  input  wire logic       dv_i,       // frame valid of the watched stream
  input  wire logic [7:0] data_i,     // byte of the watched stream
  output logic            sop_o       // start-of-packet indication
);

  // ==========================================================================
  // state
  mls_sop_state_type state_reg;
  mls_sop_state_type state_next;
  logic [3:0]        count_reg;
  logic [3:0]        count_next;
  wire               is_sfd = (data_i == SFD_BYTE);
  wire               at_limit = (count_reg == PREAMBLE_LIMIT - 4'h1);

  // next state; a frame seen while disabled is skipped to its end
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      MLS_IDLE: begin
        if (dv_i) begin
          if (!en_i) begin
            state_next = MLS_SKIP;
          end else if (!sfd_mode_i || is_sfd) begin
            state_next = MLS_ACTIVE;
          end else begin
            state_next = MLS_PRE;
            count_next = 4'h1;
          end
        end
      end
      MLS_PRE: begin
        if (!dv_i) begin
          state_next = MLS_IDLE;
        end else if (!en_i) begin
          state_next = MLS_SKIP;
        end else if (is_sfd) begin
          state_next = MLS_ACTIVE;
        end else if (at_limit) begin
          // eighth byte without delimiter
          state_next = len_chk_i ? MLS_ACTIVE : MLS_SKIP;
        end else begin
          count_next = count_reg + 4'h1;
        end
      end
      MLS_ACTIVE: begin
        if (!dv_i) begin
          state_next = MLS_IDLE;                 // held until frame end or disable
        end else if (!en_i) begin
          state_next = MLS_SKIP;
        end
      end
      MLS_SKIP: begin
        if (!dv_i) begin
          state_next = MLS_IDLE;
        end
      end
      default: begin
        state_next = MLS_IDLE;
      end
    endcase
  end

  // state flops
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= MLS_IDLE;
      count_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  assign sop_o = (state_reg == MLS_ACTIVE);

endmodule // mls_sop_detect

// ==== core/mls_top.sv ====
// Purpose: mac interface loopbacks and start-of-packet indications with axi4-lite registers
// Assumes: mac and phy byte streams run on clock_i; 10 MHz clock
// Notes:   local loop feeds the mac receive side, remote loop feeds the phy transmit side
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module mls_top
  import mls_pkg::*;
(
  input  wire logic                      clock_i,         // 10 MHz block clock
  input  wire logic                      rst_b_i,         // async reset, active low
  // axi4-lite slave
  input  wire logic [mls_pkg::ADDR_W-1:0] s_axi_awaddr_i, // write address
  input  wire logic                      s_axi_awvalid_i, // write address valid
  output logic                           s_axi_awready_o, // write address ready
  input  wire logic [mls_pkg::DATA_W-1:0] s_axi_wdata_i,  // write data
  input  wire logic [3:0]                s_axi_wstrb_i,   // write byte strobes
  input  wire logic                      s_axi_wvalid_i,  // write data valid
  output logic                           s_axi_wready_o,  // write data ready
  output logic [1:0]                     s_axi_bresp_o,   // write response
  output logic                           s_axi_bvalid_o,  // write response valid
  input  wire logic                      s_axi_bready_i,  // write response ready
  input  wire logic [mls_pkg::ADDR_W-1:0] s_axi_araddr_i, // read address
  input  wire logic                      s_axi_arvalid_i, // read address valid
  output logic                           s_axi_arready_o, // read address ready
  output logic [mls_pkg::DATA_W-1:0]     s_axi_rdata_o,   // read data
  output logic [1:0]                     s_axi_rresp_o,   // read response
  output logic                           s_axi_rvalid_o,  // read data valid
  input  wire logic                      s_axi_rready_i,  // read data ready
  // mac side
  input  wire logic [7:0]                mac_txd_i,       // transmit byte from mac
  input  wire logic                      mac_tx_en_i,     // transmit enable from mac
  output logic [7:0]                     mac_rxd_o,       // receive byte to mac
  output logic                           mac_rx_dv_o,     // receive valid to mac
  output logic                           rx_sop_o,        // receive start indication
  output logic                           tx_sop_o,        // transmit start indication
  // phy side
  input  wire logic [7:0]                phy_rxd_i,       // receive byte from phy
  input  wire logic                      phy_rx_dv_i,     // receive valid from phy
  output logic [7:0]                     phy_txd_o,       // transmit byte to phy
  output logic                           phy_tx_en_o      // transmit enable to phy
);

  // ==========================================================================
  // reset release through two flops; assertion is immediate
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // axi4-lite write channel: address and data latched in either order
  logic                aw_held_reg;
  logic [ADDR_W-1:0]   aw_addr_reg;
  logic                w_held_reg;
  logic [DATA_W-1:0]   w_data_reg;
  logic [3:0]          w_strb_reg;
  logic                bvalid_reg;
  logic [1:0]          bresp_reg;
  logic [REG_W-1:0]    loopback_reg;
  logic [REG_W-1:0]    sop_ctrl_reg;

  wire               do_write   = aw_held_reg && w_held_reg && !bvalid_reg;
  wire [15:0]        wr_index   = aw_addr_reg[ADDR_W-1:2];
  wire               wr_hit_lb  = (wr_index == LOOPBACK_IDX);
  wire               wr_hit_sop = (wr_index == SOP_CTRL_IDX);
  // only the low two lanes hold register bits; upper lanes are ignored
  wire [REG_W-1:0]   lane_mask  = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire [REG_W-1:0]   wr_low     = w_data_reg[REG_W-1:0];
  wire [REG_W-1:0]   lb_merged  = (loopback_reg & ~lane_mask) | (wr_low & lane_mask);
  wire [REG_W-1:0]   sop_merged = (sop_ctrl_reg & ~lane_mask) | (wr_low & lane_mask);

  assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready_o  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;

  // write channel holding flops and response
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (wr_hit_lb || wr_hit_sop) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // control registers; reserved bits are forced to zero
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      loopback_reg <= LOOPBACK_RST;
      sop_ctrl_reg <= SOP_CTRL_RST;
    end else if (do_write) begin
      if (wr_hit_lb) begin
        loopback_reg <= lb_merged & LOOPBACK_MASK;
      end
      if (wr_hit_sop) begin
        sop_ctrl_reg <= sop_merged & SOP_CTRL_MASK;
      end
    end
  end

  // ==========================================================================
  // axi4-lite read channel: answer one cycle after the address is taken
  logic              rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0]        rresp_reg;

  wire [15:0]        rd_index   = s_axi_araddr_i[ADDR_W-1:2];
  wire               rd_hit_lb  = (rd_index == LOOPBACK_IDX);
  wire               rd_hit_sop = (rd_index == SOP_CTRL_IDX);
  wire [REG_W-1:0]   rd_value   = rd_hit_lb  ? loopback_reg :
                                  rd_hit_sop ? sop_ctrl_reg : '0;

  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;

  // read data register
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {{(DATA_W-REG_W){1'b0}}, rd_value};
      rresp_reg  <= (rd_hit_lb || rd_hit_sop) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // loopback steering
  wire lb_en       = loopback_reg[LB_LOCAL_EN_BIT];
  wire lb_tx_supp  = loopback_reg[LB_TX_SUPP_BIT];
  wire rem_en      = loopback_reg[LB_REMOTE_EN_BIT];
  wire rem_rx_supp = loopback_reg[LB_RX_SUPP_BIT];

  // local loop wins the mac receive side; suppressed phy data reads as idle
  wire       rx_block   = rem_en && rem_rx_supp;
  wire       rx_dv_src  = lb_en ? mac_tx_en_i : (!rx_block && phy_rx_dv_i);
  wire [7:0] rx_data_src = lb_en ? mac_txd_i : (rx_block ? 8'h00 : phy_rxd_i);
  // remote loop wins the phy transmit side
  wire       tx_block   = lb_en && lb_tx_supp;
  wire       tx_en_src  = rem_en ? phy_rx_dv_i : (!tx_block && mac_tx_en_i);
  wire [7:0] tx_data_src = rem_en ? phy_rxd_i : (tx_block ? 8'h00 : mac_txd_i);

  // registered stream outputs, one cycle of latency on both paths
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      mac_rxd_o   <= 8'h00;
      mac_rx_dv_o <= 1'b0;
      phy_txd_o   <= 8'h00;
      phy_tx_en_o <= 1'b0;
    end else begin
      mac_rxd_o   <= rx_data_src;
      mac_rx_dv_o <= rx_dv_src;
      phy_txd_o   <= tx_data_src;
      phy_tx_en_o <= tx_en_src;
    end
  end

  // ==========================================================================
  // start-of-packet trackers; receive watches the stream before its output flop, transmit the mac input
  wire rx_det_en  = sop_ctrl_reg[SOP_RX_EN_BIT];
  wire rx_sfd_md  = sop_ctrl_reg[SOP_RX_SFD_BIT];
  wire rx_len_chk = sop_ctrl_reg[SOP_RX_LEN_BIT];
  wire tx_det_en  = sop_ctrl_reg[SOP_TX_EN_BIT];

  mls_sop_detect u_rx_sop (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n),
    .en_i       (rx_det_en),
    .sfd_mode_i (rx_sfd_md),
    .len_chk_i  (rx_len_chk),
    .dv_i       (rx_dv_src),
    .data_i     (rx_data_src),
    .sop_o      (rx_sop_o)
  );

  // transmit tracker sees the mac's own transmit stream
  mls_sop_detect u_tx_sop (
    .clock_i    (clock_i),
    .rst_n_i    (rst_n),
    .en_i       (tx_det_en),
    .sfd_mode_i (sop_ctrl_reg[SOP_TX_SFD_BIT]),
    .len_chk_i  (sop_ctrl_reg[SOP_TX_LEN_BIT]),
    .dv_i       (mac_tx_en_i),
    .data_i     (mac_txd_i),
    .sop_o      (tx_sop_o)
  );

  // ==========================================================================
  // assertions
  sequence s_rx_start;
    !rx_dv_src ##1 (rx_dv_src && rx_det_en);
  endsequence

  sequence s_rx_eight_plain;
    (rx_dv_src && rx_det_en && rx_sfd_md && rx_data_src != SFD_BYTE) [*8];
  endsequence

  property p_reset_values;
    @(posedge clock_i) $rose(rst_n) |->
      loopback_reg == LOOPBACK_RST && sop_ctrl_reg == SOP_CTRL_RST;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("register reset value wrong");

  property p_local_loop;
    @(posedge clock_i) disable iff (!rst_n)
      lb_en |=> mac_rxd_o == $past(mac_txd_i) && mac_rx_dv_o == $past(mac_tx_en_i);
  endproperty
  a_local_loop: assert property (p_local_loop)
    else $error("local loop data not returned to mac");

  property p_tx_suppress;
    @(posedge clock_i) disable iff (!rst_n)
      lb_en && lb_tx_supp && !rem_en |=> !phy_tx_en_o && phy_txd_o == 8'h00;
  endproperty
  a_tx_suppress: assert property (p_tx_suppress)
    else $error("looped data reached the phy");

  property p_remote_loop;
    @(posedge clock_i) disable iff (!rst_n)
      rem_en |=> phy_txd_o == $past(phy_rxd_i) && phy_tx_en_o == $past(phy_rx_dv_i);
  endproperty
  a_remote_loop: assert property (p_remote_loop)
    else $error("remote loop data not returned to phy");

  property p_rx_suppress;
    @(posedge clock_i) disable iff (!rst_n)
      rem_en && rem_rx_supp && !lb_en |=> !mac_rx_dv_o;
  endproperty
  a_rx_suppress: assert property (p_rx_suppress)
    else $error("suppressed phy data reached the mac");

  property p_rx_gated;
    @(posedge clock_i) disable iff (!rst_n)
      !rx_det_en ##1 !rx_det_en |-> !rx_sop_o;
  endproperty
  a_rx_gated: assert property (p_rx_gated)
    else $error("receive indication while disabled");

  property p_rx_on_valid;
    @(posedge clock_i) disable iff (!rst_n)
      s_rx_start ##0 !rx_sfd_md |=> rx_sop_o;
  endproperty
  a_rx_on_valid: assert property (p_rx_on_valid)
    else $error("receive indication missed valid rise");

  property p_rx_on_sfd;
    @(posedge clock_i) disable iff (!rst_n)
      s_rx_start ##0 (rx_sfd_md && rx_data_src == SFD_BYTE) |=> rx_sop_o;
  endproperty
  a_rx_on_sfd: assert property (p_rx_on_sfd)
    else $error("receive indication missed delimiter");

  property p_rx_hold;
    @(posedge clock_i) disable iff (!rst_n)
      rx_sop_o && rx_dv_src && rx_det_en |=> rx_sop_o;
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("receive indication dropped inside frame");

  property p_rx_len_on;
    @(posedge clock_i) disable iff (!rst_n)
      !rx_dv_src ##1 (s_rx_eight_plain ##0 rx_len_chk) |=> rx_sop_o;
  endproperty
  a_rx_len_on: assert property (p_rx_len_on)
    else $error("length check did not assert after eight bytes");

  property p_rx_len_off;
    @(posedge clock_i) disable iff (!rst_n)
      !rx_dv_src ##1 (s_rx_eight_plain ##0 !rx_len_chk) |=> !rx_sop_o;
  endproperty
  a_rx_len_off: assert property (p_rx_len_off)
    else $error("indication without delimiter in eight bytes");

  property p_tx_gated;
    @(posedge clock_i) disable iff (!rst_n)
      !tx_det_en ##1 !tx_det_en |-> !tx_sop_o;
  endproperty
  a_tx_gated: assert property (p_tx_gated)
    else $error("transmit indication while disabled");

  property p_tx_on_sfd;
    @(posedge clock_i) disable iff (!rst_n)
      !mac_tx_en_i ##1 (mac_tx_en_i && tx_det_en && sop_ctrl_reg[SOP_TX_SFD_BIT]
                        && mac_txd_i == SFD_BYTE) |=> tx_sop_o;
  endproperty
  a_tx_on_sfd: assert property (p_tx_on_sfd)
    else $error("transmit indication missed delimiter");

endmodule // mls_top

// ==== verification/mls_frame_src.sv ====
// Purpose: byte stream source standing in for the mac or the phy
// Assumes: one byte per clock, frames apart by idle cycles
// Notes:   idle data is the inverse of the last byte so stale data never looks valid
`timescale 1ns/10ps
module mls_frame_src (
  input  wire logic       clock_i, // stream clock
  output logic            dv_o,    // frame valid
  output logic [7:0]      data_o   // stream byte
);
  // =====
  // idle until the first frame
  initial begin
    dv_o = 1'b0;
    data_o = 8'h00;
  end

  // =====
  // preamble, optional delimiter, then four payload bytes that never match the delimiter
  task automatic send(input int npre, input bit sfd);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < npre + 4 + int'(sfd); i++) begin
      b = (i < npre) ? 8'h55 : ((i == npre && sfd) ? 8'hD5 : 8'hA0 + 8'(i));
      @(posedge clock_i);
      dv_o <= 1'b1;
      data_o <= b;
    end
    @(posedge clock_i);
    dv_o <= 1'b0;
    data_o <= ~b;
  endtask
endmodule // mls_frame_src

// ==== verification/testbench.sv ====
// Purpose: self-checking bench for mls_top
// Assumes: 10 MHz clock, two stream sources feed the mac and phy inputs
// Notes:   indication position is counted in bytes of the watched stream
`timescale 1ns/10ps
module testbench;
  import mls_pkg::*;
  localparam logic [17:0] LB_A = {LOOPBACK_IDX, 2'b00};
  localparam logic [17:0] SC_A = {SOP_CTRL_IDX, 2'b00};
  logic        clock, rst_b, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, mtx_en, mrx_dv, prx_dv, ptx_en;
  logic        rx_sop, tx_sop, rx_prev, tx_prev;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [7:0]  mtxd, mrxd, prxd, ptxd, rx_byte, rx_last, tx_last;
  int          miscompares, comparisons, rx_cnt, tx_cnt, rx_at, tx_at, rn, tn;

  mls_top u_dut (.clock_i(clock), .rst_b_i(rst_b), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .mac_txd_i(mtxd), .mac_tx_en_i(mtx_en), .mac_rxd_o(mrxd),
    .mac_rx_dv_o(mrx_dv), .rx_sop_o(rx_sop), .tx_sop_o(tx_sop), .phy_rxd_i(prxd),
    .phy_rx_dv_i(prx_dv), .phy_txd_o(ptxd), .phy_tx_en_o(ptx_en));
  mls_frame_src u_mac (.clock_i(clock), .dv_o(mtx_en), .data_o(mtxd));
  mls_frame_src u_phy (.clock_i(clock), .dv_o(prx_dv), .data_o(prxd));

  // =====
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // stream monitor: byte index at which each indication rises, byte counts per side
  always @(posedge clock) begin
    if (mrx_dv && rx_sop && !rx_prev) begin
      rx_at <= rx_cnt + 1;
      rx_byte <= mrxd;
    end
    if (rx_prev && !rx_sop && mrx_dv) chk(32'h0000_0000, 32'h0000_0001);
    if (tx_sop && !tx_prev) tx_at <= tx_cnt;
    rx_cnt <= mrx_dv ? rx_cnt + 1 : 0;
    tx_cnt <= mtx_en ? tx_cnt + 1 : 0;
    rx_prev <= rx_sop;
    tx_prev <= tx_sop;
    rn <= rn + int'(mrx_dv);
    tn <= tn + int'(ptx_en);
    // last byte seen on each output stream, so the data and not only the valid is checked
    if (mrx_dv) rx_last <= mrxd;
    if (ptx_en) tx_last <= ptxd;
  end

  // =====
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic axw(input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ap, wp;
    ap = 1'b1;
    wp = 1'b1;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (ap || wp) begin
      @(posedge clock);
      if (ap && awready) begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (wp && wready) begin
        wp = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // program both registers, send one frame, compare indication positions and counts
  task automatic frame(input logic [15:0] lb, input logic [15:0] sc, input bit phy,
      input int npre, input bit sfd, input int e_rx, input int e_tx, input int e_rn,
      input int e_tn);
    logic [7:0] last;
    last = 8'hA0 + 8'(npre + 3 + int'(sfd));
    axw(LB_A, {16'h0000, lb}, rs);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    axw(SC_A, {16'h0000, sc}, rs);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    @(negedge clock);
    rx_at = 0;
    tx_at = 0;
    rn = 0;
    tn = 0;
    rx_last = 8'h00;
    tx_last = 8'h00;
    if (phy) u_phy.send(npre, sfd);
    else u_mac.send(npre, sfd);
    repeat (3) @(posedge clock);
    chk(rx_at, e_rx);
    chk(tx_at, e_tx);
    chk(rn, e_rn);
    chk(tn, e_tn);
    chk({24'h0, rx_last}, (e_rn > 0) ? {24'h0, last} : 32'h0000_0000);
    chk({24'h0, tx_last}, (e_tn > 0) ? {24'h0, last} : 32'h0000_0000);
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // =====
  // main sequence; the watchdog allows 20000 cycles, far more than the few hundred needed
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, rx_prev, tx_prev} = 8'h00;
    {awaddr, araddr, wdata} = 68'h0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    axr(LB_A, rd, rs);
    chk(rd, 32'h0000_000A);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    axr(SC_A, rd, rs);
    chk(rd, 32'h0000_001B);
    axr(LB_A + 18'h0_0004, rd, rs);
    chk({rd[29:0], rs}, {30'h0, RESP_SLVERR});
    axw(LB_A + 18'h0_0004, 32'hFFFF_FFFF, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    axw(LB_A, 32'hFFFF_FFFF, rs);
    axr(LB_A, rd, rs);
    chk(rd, {16'h0000, LOOPBACK_MASK});
    frame(16'h000A, 16'h001B, 1, 3, 1, 4, 0, 8, 0);
    chk({24'h0, rx_byte}, {24'h0, SFD_BYTE});
    frame(16'h000A, 16'h0019, 1, 3, 1, 1, 0, 8, 0);
    frame(16'h000A, 16'h001B, 1, 0, 1, 1, 0, 5, 0);
    frame(16'h000A, 16'h001F, 1, 10, 0, 8, 0, 14, 0);
    frame(16'h000A, 16'h001B, 1, 10, 0, 0, 0, 14, 0);
    frame(16'h000A, 16'h001A, 1, 3, 1, 0, 0, 8, 0);
    frame(16'h000A, 16'h001B, 0, 3, 1, 0, 4, 0, 8);
    frame(16'h000A, 16'h001B, 0, 0, 1, 0, 1, 0, 5);
    frame(16'h000A, 16'h0013, 0, 3, 1, 0, 0, 0, 8);
    frame(16'h000A, 16'h003B, 0, 10, 0, 0, 8, 0, 14);
    frame(16'h000A, 16'h001B, 0, 10, 0, 0, 0, 0, 14);
    frame(16'h000A, 16'h000B, 0, 3, 1, 0, 1, 0, 8);
    frame(16'h0003, 16'h001B, 0, 3, 1, 4, 4, 8, 0);
    frame(16'h0001, 16'h001B, 0, 3, 1, 4, 4, 8, 8);
    frame(16'h000C, 16'h001B, 1, 3, 1, 0, 0, 0, 8);
    frame(16'h0004, 16'h001B, 1, 3, 1, 4, 0, 8, 8);
    wrap_up();
  end

  initial begin
    #2_000_000;
    miscompares++;
    wrap_up();
  end
endmodule // testbench
